// >>> mmtc_consts.vh
// Constants for the multi-mode timer channel
`ifndef MMTC_CONSTS_VH
`define MMTC_CONSTS_VH
`define MMTC_ADDR_MODE 12'h000
`define MMTC_ADDR_CTRL 12'h004
`define MMTC_ADDR_COUNT 12'h008
`define MMTC_ADDR_STAT 12'h00C
`define MMTC_MODE_TIMER 2'h0
`define MMTC_MODE_EVENT 2'h1
`define MMTC_MODE_ONESHOT 2'h2
`define MMTC_MODE_PWM 2'h3
`define MMTC_MODE_LSB 0
`define MMTC_MODE_MSB 1
`define MMTC_BIT_PULSE_OUT 2
`define MMTC_BIT_GATE 3
`define MMTC_BIT_GATE_POL 4
`define MMTC_BIT_EDGE_FALL 4
`define MMTC_BIT_DIR_PIN 5
`define MMTC_BIT_TRIG_EXT 5
`define MMTC_BIT_FREE_RUN 6
`define MMTC_BIT_DIR_UP 7
`define MMTC_BIT_SRC_NEIGH 8
`define MMTC_BIT_TWO_PHASE 9
`define MMTC_BIT_MUL4 10
`define MMTC_CLK_LSB 11
`define MMTC_CLK_MSB 12
`define MMTC_MODE_WIDTH 13
`define MMTC_MODE_RESET 13'h0000
`define MMTC_BIT_START 0
`define MMTC_BIT_OS_START 1
`define MMTC_COUNT_RESET 16'hFFFF
`define MMTC_COUNT_MAX 16'hFFFF
`define MMTC_COUNT_ZERO 16'h0000
`define MMTC_INDET_READ 16'h0000
`define MMTC_DIV_EIGHT 5'h07
`define MMTC_DIV_THIRTY_TWO 5'h1F
`endif

// >>> mmtc_sync.v
// Two-flop synchroniser for external pin levels
`timescale 1ns/1ps
module mmtc_sync #(
  parameter WIDTH = 4
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule

// >>> mmtc_timer.v
// Multi-mode 16-bit timer channel with APB register access
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "mmtc_consts.vh"
module mmtc_timer #(
  parameter CHANNEL = 2
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire channel_input_pin,
  input wire channel_output_pin_in,
  output reg channel_output_pin_out,
  output reg channel_output_pin_oe_n,
  input wire neighbour_channel_overflow,
  input wire prescaler_timer_overflow,
  output reg irq_request,
  output reg overflow_pulse
);
  // ---------------------------------------------------------------
  // Registers and pin synchronisation
  // ---------------------------------------------------------------
  localparam TWO_PHASE_OK = (CHANNEL >= 2) && (CHANNEL <= 4);
  reg [`MMTC_MODE_WIDTH-1:0] mode_reg;
  reg count_start;
  reg [15:0] reload;
  reg [15:0] counter;
  reg irq_sticky;
  reg [4:0] prescale;
  reg in_prev;
  reg out_prev;
  wire [1:0] pin_sync;
  wire in_s = pin_sync[0];
  wire out_s = pin_sync[1];
  mmtc_sync #(
    .WIDTH(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in({channel_output_pin_in, channel_input_pin}),
    .sync_out(pin_sync)
  );
  wire [1:0] mode = mode_reg[`MMTC_MODE_MSB:`MMTC_MODE_LSB];
  wire opt_pulse = mode_reg[`MMTC_BIT_PULSE_OUT];
  wire opt_gate = mode_reg[`MMTC_BIT_GATE];
  wire opt_gate_pol = mode_reg[`MMTC_BIT_GATE_POL];
  wire opt_edge_fall = mode_reg[`MMTC_BIT_EDGE_FALL];
  wire opt_dir_pin = mode_reg[`MMTC_BIT_DIR_PIN];
  wire opt_trig_ext = mode_reg[`MMTC_BIT_TRIG_EXT];
  wire opt_free = mode_reg[`MMTC_BIT_FREE_RUN];
  wire opt_dir_up = mode_reg[`MMTC_BIT_DIR_UP];
  wire opt_neigh = mode_reg[`MMTC_BIT_SRC_NEIGH];
  wire opt_two = mode_reg[`MMTC_BIT_TWO_PHASE] & TWO_PHASE_OK;
  wire opt_mul4 = mode_reg[`MMTC_BIT_MUL4];
  wire [1:0] clk_sel = mode_reg[`MMTC_CLK_MSB:`MMTC_CLK_LSB];
  // ---------------------------------------------------------------
  // Count source: clock_div_one, clock_div_eight, clock_div_thirty_two, prescaler_timer_overflow
  // ---------------------------------------------------------------
  reg tick;
  always @* begin
    case (clk_sel)
      2'h0: tick = 1'b1;
      2'h1: tick = (prescale[2:0] == `MMTC_DIV_EIGHT);
      2'h2: tick = (prescale == `MMTC_DIV_THIRTY_TWO);
      default: tick = prescaler_timer_overflow;
    endcase
  end
  wire in_rise = in_s & ~in_prev;
  wire in_fall = ~in_s & in_prev;
  wire out_rise = out_s & ~out_prev;
  wire out_fall = ~out_s & out_prev;
  // Gate level follows the chosen polarity
  wire gate_open = ~opt_gate | (in_s ^ opt_gate_pol);
  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  reg ev_step;
  reg ev_up;
  always @* begin
    ev_step = 1'b0;
    ev_up = 1'b0;
    if (opt_two) begin
      if (!opt_mul4) begin
        // Only while the other pin is high
        ev_step = out_s & (in_rise | in_fall);
        ev_up = in_rise;
      end else begin
        // Phase decides direction for every edge of both pins
        ev_step = in_rise | in_fall | out_rise | out_fall;
        ev_up = (in_rise & out_s) | (in_fall & ~out_s) |
                (out_rise & ~in_s) | (out_fall & in_s);
      end
    end else begin
      if (opt_neigh) begin
        ev_step = neighbour_channel_overflow;
      end else begin
        ev_step = opt_edge_fall ? in_fall : in_rise;
      end
      ev_up = opt_dir_pin ? out_s : opt_dir_up;
    end
  end
  wire os_trig_hw = opt_trig_ext ? in_fall : neighbour_channel_overflow;
  // ---------------------------------------------------------------
  // APB access
  // ---------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire addr_ok = (paddr == `MMTC_ADDR_MODE) | (paddr == `MMTC_ADDR_CTRL) |
                 (paddr == `MMTC_ADDR_COUNT) | (paddr == `MMTC_ADDR_STAT);
  wire wr_mode = apb_wr & (paddr == `MMTC_ADDR_MODE);
  wire wr_ctrl = apb_wr & (paddr == `MMTC_ADDR_CTRL);
  wire wr_count = apb_wr & (paddr == `MMTC_ADDR_COUNT);
  wire wr_stat = apb_wr & (paddr == `MMTC_ADDR_STAT);
  wire sw_os_start = wr_ctrl & pwdata[`MMTC_BIT_OS_START];
  reg [31:0] rd_mux;
  always @* begin
    case (paddr)
      `MMTC_ADDR_MODE: rd_mux = {19'h00000, mode_reg};
      `MMTC_ADDR_CTRL: rd_mux = {31'h00000000, count_start};
      `MMTC_ADDR_COUNT: begin
        if (mode == `MMTC_MODE_ONESHOT || mode == `MMTC_MODE_PWM) begin
          rd_mux = {16'h0000, `MMTC_INDET_READ};
        end else begin
          rd_mux = {16'h0000, counter};
        end
      end
      `MMTC_ADDR_STAT: rd_mux = {31'h00000000, irq_sticky};
      default: rd_mux = 32'h00000000;
    endcase
  end
  // One wait state: setup, access, then pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        pready <= 1'b1;
        pslverr <= ~addr_ok;
        prdata <= rd_mux;
      end else if (apb_setup) begin
        prdata <= 32'h00000000;
      end
    end
  end
  // ---------------------------------------------------------------
  // Counter core
  // ---------------------------------------------------------------
  reg [15:0] next_counter;
  reg next_start;
  reg uf;
  reg of;
  reg os_done;
  always @* begin
    next_counter = counter;
    next_start = count_start;
    uf = 1'b0;
    of = 1'b0;
    os_done = 1'b0;
    case (mode)
      `MMTC_MODE_TIMER: begin
        if (count_start && tick && gate_open) begin
          if (counter == `MMTC_COUNT_ZERO) begin
            uf = 1'b1;
            next_counter = reload;
          end else begin
            next_counter = counter - 16'h0001;
          end
        end
      end
      `MMTC_MODE_EVENT: begin
        if (count_start && ev_step) begin
          if (ev_up) begin
            if (counter == `MMTC_COUNT_MAX) begin
              of = 1'b1;
              next_counter = opt_free ? `MMTC_COUNT_ZERO : reload;
            end else begin
              next_counter = counter + 16'h0001;
            end
          end else begin
            if (counter == `MMTC_COUNT_ZERO) begin
              uf = 1'b1;
              next_counter = opt_free ? `MMTC_COUNT_MAX : reload;
            end else begin
              next_counter = counter - 16'h0001;
            end
          end
        end
      end
      `MMTC_MODE_ONESHOT: begin
        if (count_start && (os_trig_hw || sw_os_start)) begin
          next_counter = reload;
        end else if (count_start && tick && counter != `MMTC_COUNT_ZERO) begin
          if (counter == 16'h0001) begin
            os_done = 1'b1;
            next_counter = reload;
          end else begin
            next_counter = counter - 16'h0001;
          end
        end
      end
      default: begin
        next_counter = counter;
      end
    endcase
    if (wr_ctrl) begin
      next_start = pwdata[`MMTC_BIT_START];
    end
    if (wr_count && !count_start) begin
      next_counter = pwdata[15:0];
    end
  end
  // One-shot idles at zero between runs; the counter parks at zero, not reload, on finish
  reg os_running;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `MMTC_MODE_RESET;
      count_start <= 1'b0;
      reload <= `MMTC_COUNT_RESET;
      counter <= `MMTC_COUNT_RESET;
      irq_sticky <= 1'b0;
      irq_request <= 1'b0;
      overflow_pulse <= 1'b0;
      prescale <= 5'h00;
      in_prev <= 1'b0;
      out_prev <= 1'b0;
      os_running <= 1'b0;
      channel_output_pin_out <= 1'b0;
      channel_output_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      prescale <= prescale + 5'h01;
      in_prev <= in_s;
      out_prev <= out_s;
      count_start <= next_start;
      if (wr_mode) begin
        mode_reg <= pwdata[`MMTC_MODE_WIDTH-1:0];
      end
      if (wr_count) begin
        reload <= pwdata[15:0];
      end
      if (mode == `MMTC_MODE_ONESHOT) begin
        if (!count_start) begin
          os_running <= 1'b0;
          counter <= next_counter;
        end else if (os_trig_hw || sw_os_start) begin
          os_running <= 1'b1;
          counter <= next_counter;
        end else if (os_running) begin
          counter <= os_done ? `MMTC_COUNT_ZERO : next_counter;
          if (os_done) begin
            os_running <= 1'b0;
          end
        end
      end else begin
        os_running <= 1'b0;
        counter <= next_counter;
      end
      irq_request <= uf | (of & (mode == `MMTC_MODE_EVENT)) |
                     (os_done & os_running);
      overflow_pulse <= uf | of;
      // Set wins over the software clear
      if (uf | of | (os_done & os_running)) begin
        irq_sticky <= 1'b1;
      end else if (wr_stat && pwdata[0]) begin
        irq_sticky <= 1'b0;
      end
      channel_output_pin_oe_n <= ~(opt_pulse & ~opt_two &
                                   ~(opt_dir_pin & (mode == `MMTC_MODE_EVENT)));
      if (uf && opt_pulse) begin
        channel_output_pin_out <= ~channel_output_pin_out;
      end
    end
  end
endmodule

// >>> mmtc_timer_assertions.sv
// Port checker for the timer channel
`timescale 1ns/1ps
`include "mmtc_consts.vh"
module mmtc_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire channel_output_pin_out,
  input wire channel_output_pin_oe_n,
  input wire irq_request,
  input wire overflow_pulse
);
  // --------
  // Shadow of mode and start, taken at the commit edge
  // --------
  reg [12:0] mode;
  reg run;
  wire wr = psel && penable && pready && pwrite;
  wire pulse_en = mode[`MMTC_BIT_PULSE_OUT];
  wire two_ph = mode[1:0] == `MMTC_MODE_EVENT && mode[`MMTC_BIT_TWO_PHASE];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MMTC_MODE_RESET;
      run <= 1'b0;
    end else if (wr && paddr == `MMTC_ADDR_MODE) begin
      mode <= pwdata[12:0];
    end else if (wr && paddr == `MMTC_ADDR_CTRL) begin
      run <= pwdata[`MMTC_BIT_START];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("no ready one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_DATA: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read not zero");
  // Two cycles of slack cover an underflow already in the pipe at stop
  AST_STOP_QUIET: assert property (!run && !$past(run) && !$past(run, 2) |-> !overflow_pulse)
    else $error("count event while stopped");
  AST_IRQ_FOLLOWS: assert property (overflow_pulse |-> ##[0:1] irq_request)
    else $error("wrap without request");
  AST_PIN_HOLD: assert property (!pulse_en && !$past(pulse_en) |-> $stable(channel_output_pin_out))
    else $error("output moved with pulse option off");
  AST_PIN_TOGGLE: assert property ($changed(channel_output_pin_out) && pulse_en
    |-> ##[0:2] $past(overflow_pulse))
    else $error("output toggled away from underflow");
  AST_TWO_PH_IN: assert property (two_ph && $past(two_ph) |-> channel_output_pin_oe_n)
    else $error("output driven in two-phase mode");
  cover property (overflow_pulse && pulse_en);
  cover property (pready && pslverr);
  cover property (irq_request && mode[1:0] == `MMTC_MODE_ONESHOT);
endmodule
bind mmtc_timer mmtc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .channel_output_pin_out(channel_output_pin_out),
  .channel_output_pin_oe_n(channel_output_pin_oe_n), .irq_request(irq_request),
  .overflow_pulse(overflow_pulse));

// >>> mmtc_pins.sv
// Far-side pin model: quadrature source on the two channel pins
`timescale 1ns/1ps
module mmtc_pins (
  input wire pclk,
  input wire run,
  input wire back,
  input wire slow,
  output wire pin_a,
  output wire pin_b
);
  reg [3:0] div = 4'h0;
  reg [1:0] ph = 2'h0;
  // Gray order, so only one pin moves per step
  assign pin_a = ph[1];
  assign pin_b = ph[1] ^ ph[0];
  // Steps 4 or 16 cycles apart, both beyond the synchroniser delay
  always @(posedge pclk) begin
    div <= div + 4'h1;
    if (run && div[1:0] == 2'h3 && (!slow || div[3:2] == 2'h3)) begin
      ph <= back ? ph - 2'h1 : ph + 2'h1;
    end
  end
endmodule

// >>> multi_mode_timer_channel_test.sv
// Self-checking bench for the multi-mode timer channel
`timescale 1ns/1ps
`include "mmtc_consts.vh"
module multi_mode_timer_channel_test;
  reg pclk, presetn, psel, penable, pwrite, neigh, pd_run, pd_back, pd_slow, pa_q, pb_q, out_q;
  reg [11:0] paddr;
  reg [31:0] pwdata, seed, n, m, base;
  wire [31:0] prdata;
  wire pready, pslverr, out, oe_n, irq, ovf, pin_a, pin_b;
  wire line = oe_n ? pin_b : out;
  logic [32:0] q_rd[$];
  int q_per[$];
  int n_fail, samples_checked, cyc, last, n_ovf, n_irq, rises, edges, k, n_tog;
  mmtc_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_input_pin(pin_a),
    .channel_output_pin_in(line), .channel_output_pin_out(out),
    .channel_output_pin_oe_n(oe_n), .neighbour_channel_overflow(neigh),
    .prescaler_timer_overflow(1'b0), .irq_request(irq), .overflow_pulse(ovf));
  mmtc_pins far (.pclk(pclk), .run(pd_run), .back(pd_back), .slow(pd_slow), .pin_a(pin_a),
    .pin_b(pin_b));
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out;
  end
  // --------
  // Result watcher
  // --------
  always @(posedge pclk) begin
    cyc++;
    pa_q <= pin_a;
    pb_q <= pin_b;
    n_tog += (out !== out_q);
    out_q <= out;
    rises += (pin_a && !pa_q);
    edges += (pin_a != pa_q) + (pin_b != pb_q);
    if (irq === 1'b1) n_irq++;
    if (pready === 1'b1 && pwrite === 1'b0 && q_rd.size() > 0) chk({pslverr, prdata}, q_rd.pop_front());
    if (ovf === 1'b1) begin
      if (q_per.size() > 0) chk(cyc - last, q_per.pop_front());
      last = cyc;
      n_ovf++;
    end
  end
  // --------
  // Scenarios
  // --------
  initial begin
    {presetn, psel, penable, pwrite, neigh, pd_run, pd_back, pd_slow, pa_q, pb_q, out_q} = 11'h000;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    seed = 32'hB8BE9501;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`MMTC_ADDR_MODE, 33'h000000000);
    rd(`MMTC_ADDR_CTRL, 33'h000000000);
    rd(`MMTC_ADDR_COUNT, 33'h00000FFFF);
    rd(`MMTC_ADDR_STAT, 33'h000000000);
    rd(12'h010, 33'h100000000);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      n = 32'h00000006 + seed[2:0];
      seed = lfsr(seed);
      m = 32'h00000006 + seed[3:0];
      apb(1'b1, `MMTC_ADDR_COUNT, n);
      apb(1'b1, `MMTC_ADDR_MODE, {19'h00000, i[1:0], 11'h004});
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000001);
      k = n_ovf;
      wait (n_ovf == k + 1);
      q_per.push_back((n + 1) << (3 * i));
      wait (n_ovf == k + 2);
      apb(1'b1, `MMTC_ADDR_COUNT, m);
      q_per.push_back((n + 1) << (3 * i));
      q_per.push_back((m + 1) << (3 * i));
      wait (n_ovf == k + 4);
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000000);
    end
    chk(n_tog, n_ovf);
    chk(n_irq, n_ovf);
    // --------
    // Single down, single up, times-four both ways, normal two-phase, pin direction
    // --------
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `MMTC_ADDR_COUNT, 32'h00001000);
      m = i == 0 ? 32'h00000001 : i == 1 ? 32'h00000081 : i < 4 ? 32'h00000681 :
          i == 4 ? 32'h00000281 : 32'h00000021;
      apb(1'b1, `MMTC_ADDR_MODE, m);
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000001);
      rises = 0;
      edges = 0;
      pd_back <= i == 3;
      pd_slow <= i[0];
      pd_run <= 1'b1;
      repeat (150) @(posedge pclk);
      pd_run <= 1'b0;
      repeat (8) @(posedge pclk);
      k = (i == 2 || i == 3) ? edges : rises;
      rd(`MMTC_ADDR_COUNT, (i == 0 || i == 3) ? 33'h1000 - k : 33'h1000 + k);
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000000);
    end
    // --------
    // Gate shut by the pin level, then opened by the opposite polarity
    // --------
    apb(1'b1, `MMTC_ADDR_COUNT, 32'h00000005);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `MMTC_ADDR_MODE, {27'h0000000, pin_a ^ i[0], 4'h8});
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000001);
      k = n_ovf;
      repeat (40) @(posedge pclk);
      chk(n_ovf - k > 0, i);
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000000);
    end
    // --------
    // Neighbour overflows counted up across the top, wrapping and reloading
    // --------
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `MMTC_ADDR_COUNT, 32'h0000FFFE);
      apb(1'b1, `MMTC_ADDR_MODE, i ? 32'h00000181 : 32'h000001C1);
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000001);
      base = n_irq;
      repeat (3) begin
        neigh <= 1'b1;
        @(posedge pclk);
        neigh <= 1'b0;
        @(posedge pclk);
      end
      @(posedge pclk);
      chk(n_irq - base, 33'h000000001);
      rd(`MMTC_ADDR_COUNT, i ? 33'h00000FFFF : 33'h000000001);
      apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000000);
    end
    // --------
    // One-shot: software start, then a neighbour trigger retriggered mid-run
    // --------
    apb(1'b1, `MMTC_ADDR_COUNT, 32'h00000010);
    apb(1'b1, `MMTC_ADDR_MODE, 32'h00000002);
    // One-shot start only acts once the count start flag is already set
    apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000001);
    for (int i = 0; i < 2; i++) begin
      base = n_irq;
      if (i == 0) begin
        apb(1'b1, `MMTC_ADDR_CTRL, 32'h00000003);
      end else begin
        repeat (2) begin
          neigh <= 1'b1;
          @(posedge pclk);
          neigh <= 1'b0;
          repeat (10) @(posedge pclk);
        end
        chk(n_irq - base, 33'h000000000);
      end
      repeat (60) @(posedge pclk);
      chk(n_irq - base, 33'h000000001);
    end
    rd(`MMTC_ADDR_COUNT, 33'h000000000);
    rd(`MMTC_ADDR_STAT, 33'h000000001);
    apb(1'b1, `MMTC_ADDR_STAT, 32'h00000001);
    rd(`MMTC_ADDR_STAT, 33'h000000000);
    close_out;
  end
endmodule
